//--- power_mode_controller.sv
// Power mode controller: active mode, cpu idle and three sleep levels
// Operation
// - One active mode plus cpu idle, light, deep and deepest sleep levels
// - Enter strobe with no level selected gates CPU clock until an interrupt
// - Light sleep stops both fast oscillators; regulator and slow oscillator stay
// - Deep sleep switches regulator off; slow oscillator keeps running; state kept
// - Deepest sleep stops regulator and all oscillators; only reset and ports wake
// - Deep and deepest sleep discard USB controller state
// - Port event wakes any sleep; sleep timer wakes light and deep, resuming
// - Any enabled interrupt ends cpu idle and execution resumes
// - Reset from any low-power mode returns to active, restarting the program
// - I/O pins hold direction and level through light, deep and deepest sleep
// - Power down sequence on entry; light fast, deepest same as deep
// - Wake restarts prior fast oscillators; crystal source runs on RC until stable
// - Level entered is the selector value when the enter strobe is written
// - Port, sleep timer or power-on wake clears selector and enter strobe
// - Nonzero selector blocks port and sleep timer interrupt service
// - Enter strobe always reads back as zero
// - Selector returns to zero once the sleep level is actually entered
`timescale 1ns/100ps
`include "power_mode_controller_defines.svh"
module power_mode_controller (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Software writes and read back
    input wire logic mode_select_wr,
    input wire logic [1:0] mode_select_wdata,
    input wire logic sleep_enter_strobe,
    output logic [1:0] mode_select_rdata,
    output logic enter_strobe_rdata,
    // Clock configuration from software
    input wire logic system_clock_source_select,
    input wire logic fast_crystal_request,
    input wire logic fast_rc_request,
    // Oscillator status pins
    input wire logic crystal_stable_pin,
    input wire logic fast_rc_stable_pin,
    // Wake and interrupt sources
    input wire logic port_event_pin,
    input wire logic sleep_timer_irq,
    input wire logic enabled_irq,
    // Controls and status
    output logic cpu_clock_en,
    output logic system_clock_use_rc,
    output logic wake_irq_block,
    output power_mode_pkg::power_ctrl_type power_ctrl,
    output power_mode_pkg::sleep_side_type sleep_side,
    output power_mode_pkg::sleep_level_type sleep_level,
    output logic crystal_stable_flag
);
    logic [2:0] pin_raw;
    logic [2:0] pin_s;
    logic rc_stable_s;
    logic port_event_s;

    power_mode_pkg::pmc_state_type state_q, state_d;
    power_mode_pkg::sleep_level_type level_q, level_d;
    logic [1:0] select_q, select_d;
    logic [`PMC_CNT_W-1:0] cnt_q, cnt_d;
    logic saved_xosc_q, saved_xosc_d;
    logic saved_rc_q, saved_rc_d;
    logic use_rc_q, use_rc_d;
    logic switch_gap_q, switch_gap_d;
    logic cpu_en_q, cpu_en_d;
    power_mode_pkg::power_ctrl_type ctrl_q, ctrl_d;
    power_mode_pkg::sleep_side_type side_q, side_d;
    logic wake_ok;
    logic clock_ready;

    assign pin_raw = {crystal_stable_pin, fast_rc_stable_pin, port_event_pin};

    pin_sync #(.WIDTH(3)) u_pin_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    assign crystal_stable_flag = pin_s[2];
    assign rc_stable_s = pin_s[1];
    assign port_event_s = pin_s[0];

    // Sleep timer cannot wake the deepest level since its oscillator is off
    assign wake_ok = port_event_s ||
        (sleep_timer_irq && level_q != power_mode_pkg::deepest_sleep_mode);

    // A fast source must really run before the CPU clock opens
    assign clock_ready = use_rc_q ? rc_stable_s :
        (saved_xosc_q ? crystal_stable_flag : rc_stable_s);

    function automatic logic [`PMC_CNT_W-1:0] down_len(input logic [1:0] lvl);
        down_len = (lvl == `PMC_SEL_LIGHT) ? `PMC_LIGHT_DOWN_CYC : `PMC_DEEP_DOWN_CYC;
    endfunction

    function automatic logic [`PMC_CNT_W-1:0] up_len(input logic [1:0] lvl);
        up_len = (lvl == `PMC_SEL_LIGHT) ? `PMC_LIGHT_UP_CYC : `PMC_DEEP_UP_CYC;
    endfunction

    always_comb begin
        state_d = state_q;
        level_d = level_q;
        select_d = select_q;
        cnt_d = cnt_q;
        saved_xosc_d = saved_xosc_q;
        saved_rc_d = saved_rc_q;
        use_rc_d = use_rc_q;
        switch_gap_d = 1'b0;
        case (state_q)
            power_mode_pkg::st_active: begin
                if (use_rc_q && crystal_stable_flag) begin
                    use_rc_d = 1'b0;
                    switch_gap_d = 1'b1;
                end
                if (sleep_enter_strobe && select_q == `PMC_SEL_NONE) begin
                    state_d = power_mode_pkg::st_cpu_gated;
                end else if (sleep_enter_strobe) begin
                    level_d = power_mode_pkg::sleep_level_type'(select_q);
                    saved_xosc_d = fast_crystal_request;
                    saved_rc_d = fast_rc_request;
                    cnt_d = down_len(select_q);
                    state_d = power_mode_pkg::st_power_down;
                end
            end
            power_mode_pkg::st_cpu_gated: begin
                if (enabled_irq) begin
                    state_d = power_mode_pkg::st_active;
                end
            end
            power_mode_pkg::st_power_down: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    state_d = power_mode_pkg::st_asleep;
                    select_d = `PMC_SEL_NONE;
                end
            end
            power_mode_pkg::st_asleep: begin
                if (wake_ok) begin
                    select_d = `PMC_SEL_NONE;
                    cnt_d = up_len(level_q);
                    use_rc_d = (system_clock_source_select == `PMC_SRC_CRYSTAL) &&
                        !crystal_stable_flag;
                    state_d = power_mode_pkg::st_power_up;
                end
            end
            power_mode_pkg::st_power_up: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    state_d = power_mode_pkg::st_clock_wait;
                end
            end
            power_mode_pkg::st_clock_wait: begin
                if (clock_ready) begin
                    state_d = power_mode_pkg::st_active;
                end
            end
            default: begin
                state_d = power_mode_pkg::st_active;
            end
        endcase
        // Software write beats a hardware clear in the same cycle
        if (mode_select_wr) begin
            select_d = mode_select_wdata;
        end
    end

    // Controls are computed from the next state so they change with it
    always_comb begin
        ctrl_d.fast_crystal_en = fast_crystal_request;
        ctrl_d.fast_rc_en = fast_rc_request || use_rc_d;
        ctrl_d.slow_osc_en = 1'b1;
        ctrl_d.core_regulator_en = 1'b1;
        side_d = '0;
        cpu_en_d = 1'b1;
        case (state_d)
            power_mode_pkg::st_cpu_gated: begin
                cpu_en_d = 1'b0;
            end
            power_mode_pkg::st_power_down,
            power_mode_pkg::st_asleep: begin
                cpu_en_d = 1'b0;
                ctrl_d.fast_crystal_en = 1'b0;
                ctrl_d.fast_rc_en = 1'b0;
                side_d.io_hold = 1'b1;
                if (level_d != power_mode_pkg::light_sleep_mode) begin
                    ctrl_d.core_regulator_en = 1'b0;
                    side_d.usb_state_reset = 1'b1;
                end
                if (level_d == power_mode_pkg::deepest_sleep_mode) begin
                    ctrl_d.slow_osc_en = 1'b0;
                end
            end
            power_mode_pkg::st_power_up,
            power_mode_pkg::st_clock_wait: begin
                cpu_en_d = 1'b0;
                side_d.io_hold = 1'b1;
                ctrl_d.fast_crystal_en = saved_xosc_d;
                ctrl_d.fast_rc_en = saved_rc_d || use_rc_d;
            end
            default: begin
                cpu_en_d = !switch_gap_d;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= power_mode_pkg::st_active;
            level_q <= power_mode_pkg::cpu_gated_mode;
            select_q <= `PMC_SEL_NONE;
            cnt_q <= '0;
            saved_xosc_q <= 1'b0;
            saved_rc_q <= 1'b1;
            use_rc_q <= 1'b0;
            switch_gap_q <= 1'b0;
            cpu_en_q <= 1'b1;
            ctrl_q <= 4'hf;
            side_q <= 2'h0;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            select_q <= select_d;
            cnt_q <= cnt_d;
            saved_xosc_q <= saved_xosc_d;
            saved_rc_q <= saved_rc_d;
            use_rc_q <= use_rc_d;
            switch_gap_q <= switch_gap_d;
            cpu_en_q <= cpu_en_d;
            ctrl_q <= ctrl_d;
            side_q <= side_d;
        end
    end

    assign mode_select_rdata = select_q;
    assign enter_strobe_rdata = 1'b0;
    assign wake_irq_block = (select_q != `PMC_SEL_NONE);
    assign cpu_clock_en = cpu_en_q;
    assign system_clock_use_rc = use_rc_q;
    assign power_ctrl = ctrl_q;
    assign sleep_side = side_q;
    assign sleep_level = level_q;

    sequence s_enter_sleep;
        state_q == power_mode_pkg::st_active && sleep_enter_strobe &&
            select_q != `PMC_SEL_NONE;
    endsequence

    sequence s_wake;
        state_q == power_mode_pkg::st_asleep && wake_ok;
    endsequence

    a_idle_gates_cpu: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_active && sleep_enter_strobe &&
            select_q == `PMC_SEL_NONE |=> !cpu_clock_en until enabled_irq)
        else $error("cpu clock not gated in idle");
    a_idle_exit: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_cpu_gated && enabled_irq |=> ##1 cpu_clock_en)
        else $error("idle not left on interrupt");
    a_light_fast_off: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_asleep |->
            !power_ctrl.fast_crystal_en && !power_ctrl.fast_rc_en && sleep_side.io_hold)
        else $error("fast oscillator running while asleep");
    a_deep_reg_off: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_asleep &&
            level_q == power_mode_pkg::deep_sleep_mode |->
            !power_ctrl.core_regulator_en && power_ctrl.slow_osc_en &&
            sleep_side.usb_state_reset)
        else $error("deep sleep controls wrong");
    a_deepest_all_off: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_asleep &&
            level_q == power_mode_pkg::deepest_sleep_mode |->
            !power_ctrl.slow_osc_en && !power_ctrl.core_regulator_en)
        else $error("deepest sleep oscillator on");
    a_deepest_timer: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_asleep &&
            level_q == power_mode_pkg::deepest_sleep_mode && !port_event_s |=>
            state_q == power_mode_pkg::st_asleep)
        else $error("deepest sleep left without port event");
    a_down_length: assert property (@(posedge clk_sys) disable iff (reset)
        (s_enter_sleep and (select_q == `PMC_SEL_LIGHT)) |=> ##3
            state_q == power_mode_pkg::st_asleep)
        else $error("light power down length wrong");
    a_select_clear: assert property (@(posedge clk_sys) disable iff (reset)
        state_q == power_mode_pkg::st_power_down && cnt_q == '0 && !mode_select_wr |=>
            mode_select_rdata == `PMC_SEL_NONE && !wake_irq_block)
        else $error("selector not cleared on sleep entry");
    a_wake_clear: assert property (@(posedge clk_sys) disable iff (reset)
        s_wake ##0 !mode_select_wr |=> mode_select_rdata == `PMC_SEL_NONE &&
            state_q == power_mode_pkg::st_power_up)
        else $error("wake did not clear selector");
    a_block_irq: assert property (@(posedge clk_sys) disable iff (reset)
        mode_select_rdata != `PMC_SEL_NONE |-> wake_irq_block)
        else $error("interrupts not blocked");
    a_strobe_zero: assert property (@(posedge clk_sys) disable iff (reset)
        sleep_enter_strobe |=> !enter_strobe_rdata)
        else $error("enter strobe read back nonzero");
    a_resume_clock: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cpu_clock_en) && $past(state_q) == power_mode_pkg::st_clock_wait |->
            (power_ctrl.fast_rc_en || power_ctrl.fast_crystal_en))
        else $error("cpu resumed without a fast clock");
    a_rc_fallback: assert property (@(posedge clk_sys) disable iff (reset)
        s_wake ##0 system_clock_source_select == `PMC_SRC_CRYSTAL &&
            !crystal_stable_flag |=> system_clock_use_rc && power_ctrl.fast_rc_en)
        else $error("no RC fallback on crystal wake");
endmodule

//--- power_mode_controller_defines.svh
// Timing counts and field codes for the power mode controller
`ifndef POWER_MODE_CONTROLLER_DEFINES_SVH
`define POWER_MODE_CONTROLLER_DEFINES_SVH

// Sleep level selector codes
`define PMC_SEL_NONE 2'h0
`define PMC_SEL_LIGHT 2'h1
`define PMC_SEL_DEEP 2'h2
`define PMC_SEL_DEEPEST 2'h3

// Clock source select value that picks the fast crystal
`define PMC_SRC_CRYSTAL 1'h0

// Power down and power up counter loads; each sequence lasts this many clk_sys cycles plus one
`define PMC_LIGHT_DOWN_CYC 5'h02
`define PMC_LIGHT_UP_CYC 5'h02
`define PMC_DEEP_DOWN_CYC 5'h0c
`define PMC_DEEP_UP_CYC 5'h0c

// Sequence counter width
`define PMC_CNT_W 5

`endif

//--- power_mode_pkg.sv
// Types shared by the power mode controller files
package power_mode_pkg;

    // Sleep level held in the mode selector
    typedef enum logic [1:0] {
        cpu_gated_mode = 2'h0,
        light_sleep_mode = 2'h1,
        deep_sleep_mode = 2'h2,
        deepest_sleep_mode = 2'h3
    } sleep_level_type;

    // Controller states, one-hot
    typedef enum logic [5:0] {
        st_active = 6'h01,
        st_cpu_gated = 6'h02,
        st_power_down = 6'h04,
        st_asleep = 6'h08,
        st_power_up = 6'h10,
        st_clock_wait = 6'h20
    } pmc_state_type;

    // Supply and oscillator controls driven towards the analog side
    typedef struct packed {
        logic fast_crystal_en;
        logic fast_rc_en;
        logic slow_osc_en;
        logic core_regulator_en;
    } power_ctrl_type;

    // Pin side controls while asleep
    typedef struct packed {
        logic io_hold;
        logic usb_state_reset;
    } sleep_side_type;

endpackage

//--- pin_sync.sv
// Three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Asynchronous inputs and filtered result
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync width must be at least one");
        end
    endgenerate

    // A change is accepted only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign sync_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : sync_q[i];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

//--- tb_power_mode_controller.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/100ps
`include "power_mode_controller_defines.svh"
module tb_power_mode_controller;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic mode_select_wr = 1'h0;
    logic [1:0] mode_select_wdata = 2'h0;
    logic sleep_enter_strobe = 1'h0;
    logic system_clock_source_select = 1'h1;
    logic fast_crystal_request = 1'h1;
    logic fast_rc_request = 1'h1;
    logic crystal_stable_pin = 1'h1;
    logic fast_rc_stable_pin = 1'h1;
    logic port_event_pin = 1'h0;
    logic sleep_timer_irq = 1'h0;
    logic enabled_irq = 1'h0;
    logic [1:0] mode_select_rdata;
    logic enter_strobe_rdata;
    logic cpu_clock_en;
    logic system_clock_use_rc;
    logic wake_irq_block;
    logic crystal_stable_flag;
    power_mode_pkg::power_ctrl_type power_ctrl;
    power_mode_pkg::sleep_side_type sleep_side;
    power_mode_pkg::sleep_level_type sleep_level;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;

    power_mode_controller dut_u (
        .clk_sys(clk_sys),
        .reset(reset),
        .mode_select_wr(mode_select_wr),
        .mode_select_wdata(mode_select_wdata),
        .sleep_enter_strobe(sleep_enter_strobe),
        .mode_select_rdata(mode_select_rdata),
        .enter_strobe_rdata(enter_strobe_rdata),
        .system_clock_source_select(system_clock_source_select),
        .fast_crystal_request(fast_crystal_request),
        .fast_rc_request(fast_rc_request),
        .crystal_stable_pin(crystal_stable_pin),
        .fast_rc_stable_pin(fast_rc_stable_pin),
        .port_event_pin(port_event_pin),
        .sleep_timer_irq(sleep_timer_irq),
        .enabled_irq(enabled_irq),
        .cpu_clock_en(cpu_clock_en),
        .system_clock_use_rc(system_clock_use_rc),
        .wake_irq_block(wake_irq_block),
        .power_ctrl(power_ctrl),
        .sleep_side(sleep_side),
        .sleep_level(sleep_level),
        .crystal_stable_flag(crystal_stable_flag)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is well under 1000 cycles, so this only trips on a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            $display("unexpected cycle_limit expected %0d seen %0d", 3999, cycles);
            complete_run();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [3:0] probe(input int which);
        case (which)
            0: probe = {3'h0, cpu_clock_en};
            1: probe = {2'h0, mode_select_rdata};
            3: probe = {3'h0, crystal_stable_flag};
            default: probe = {3'h0, system_clock_use_rc};
        endcase
    endfunction

    // Bounded wait; sampled 1 ns after the edge so that edge's updates have landed
    task automatic wait_for(input string what, input int which, input logic [3:0] exp,
                            input int limit);
        int k = 0;
        while (probe(which) !== exp && k < limit) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        check(what, exp, probe(which));
    endtask

    task automatic write_sel(input logic [1:0] v);
        @(posedge clk_sys);
        mode_select_wr <= 1'h1;
        mode_select_wdata <= v;
        @(posedge clk_sys);
        mode_select_wr <= 1'h0;
        #1;
    endtask

    task automatic pulse_strobe();
        @(posedge clk_sys);
        sleep_enter_strobe <= 1'h1;
        @(posedge clk_sys);
        sleep_enter_strobe <= 1'h0;
        #1;
    endtask

    task automatic enter_sleep(input logic [1:0] lvl);
        wait_for("xtal_before_sleep", 3, 4'h1, 8);
        write_sel(lvl);
        check("select_rdata", {2'h0, lvl}, {2'h0, mode_select_rdata});
        check("irq_block", 4'h1, {3'h0, wake_irq_block});
        tick(3);
        pulse_strobe();
        check("strobe_rdata", 4'h0, {3'h0, enter_strobe_rdata});
        wait_for("select_clear", 1, 4'h0, 40);
        check("irq_block_asleep", 4'h0, {3'h0, wake_irq_block});
    endtask

    // Wake by the sleep timer when by_port is 0; drop_xtal loses the crystal while asleep
    task automatic sleep_cycle(input logic [1:0] lvl, input logic [3:0] pwr, input logic by_port,
                               input logic drop_xtal);
        enter_sleep(lvl);
        check("sleep_level", {2'h0, lvl}, {2'h0, sleep_level});
        check("power_ctrl", pwr, power_ctrl);
        check("io_hold", 4'h1, {3'h0, sleep_side.io_hold});
        check("usb_reset", {3'h0, lvl != 2'h1}, {3'h0, sleep_side.usb_state_reset});
        check("cpu_asleep", 4'h0, {3'h0, cpu_clock_en});
        @(posedge clk_sys);
        crystal_stable_pin <= ~drop_xtal;
        if (lvl == `PMC_SEL_DEEPEST) begin
            sleep_timer_irq <= 1'h1;
            tick(20);
            sleep_timer_irq <= 1'h0;
            #1;
            check("deepest_timer", 4'h0, {3'h0, cpu_clock_en});
            @(posedge clk_sys);
        end
        sleep_timer_irq <= ~by_port;
        port_event_pin <= by_port;
        wait_for("cpu_wake", 0, 4'h1, 80);
        @(posedge clk_sys);
        sleep_timer_irq <= 1'h0;
        port_event_pin <= 1'h0;
        #1;
        check("io_hold_awake", 4'h0, {3'h0, sleep_side.io_hold});
        check("select_woken", 4'h0, {2'h0, mode_select_rdata});
        check("power_awake", 4'hf, power_ctrl);
        if (drop_xtal) begin
            check("use_rc", 4'h1, {3'h0, system_clock_use_rc});
            check("xtal_flag", 4'h0, {3'h0, crystal_stable_flag});
            @(posedge clk_sys);
            crystal_stable_pin <= 1'h1;
            wait_for("use_rc_clear", 2, 4'h0, 12);
            check("switch_gap", 4'h0, {3'h0, cpu_clock_en});
            tick(3);
            #1;
            check("cpu_after_switch", 4'h1, {3'h0, cpu_clock_en});
            check("power_after_switch", 4'hb, power_ctrl);
        end
    endtask

    initial begin
        tick(8);
        #1;
        check("reset_power", 4'hf, power_ctrl);
        check("reset_strobe", 4'h0, {3'h0, enter_strobe_rdata});
        check("reset_select", 4'h0, {2'h0, mode_select_rdata});
        @(posedge clk_sys);
        reset <= 1'h0;
        tick(4);
        // Selector left at none: the strobe only gates the CPU clock
        pulse_strobe();
        tick(2);
        #1;
        check("idle_cpu", 4'h0, {3'h0, cpu_clock_en});
        check("idle_power", 4'hf, power_ctrl);
        @(posedge clk_sys);
        enabled_irq <= 1'h1;
        @(posedge clk_sys);
        enabled_irq <= 1'h0;
        #1;
        wait_for("idle_wake", 0, 4'h1, 4);
        // A service routine that fires before sleep clears the selector itself
        write_sel(`PMC_SEL_DEEP);
        write_sel(`PMC_SEL_NONE);
        check("isr_clear", 4'h0, {3'h0, wake_irq_block});
        sleep_cycle(`PMC_SEL_LIGHT, 4'h3, 1'h0, 1'h0);
        sleep_cycle(`PMC_SEL_DEEP, 4'h2, 1'h1, 1'h0);
        sleep_cycle(`PMC_SEL_DEEPEST, 4'h0, 1'h1, 1'h0);
        @(posedge clk_sys);
        system_clock_source_select <= `PMC_SRC_CRYSTAL;
        fast_rc_request <= 1'h0;
        tick(2);
        sleep_cycle(`PMC_SEL_LIGHT, 4'h3, 1'h1, 1'h1);
        // Reset while in deep sleep must bring everything back up at once
        enter_sleep(`PMC_SEL_DEEP);
        @(posedge clk_sys);
        reset <= 1'h1;
        tick(4);
        #1;
        check("rst_sleep_cpu", 4'h1, {3'h0, cpu_clock_en});
        check("rst_sleep_power", 4'hf, power_ctrl);
        check("rst_sleep_side", 4'h0, {2'h0, sleep_side});
        @(posedge clk_sys);
        reset <= 1'h0;
        tick(3);
        #1;
        check("after_reset_cpu", 4'h1, {3'h0, cpu_clock_en});
        complete_run();
    end
endmodule
